// [gpp_pkg.sv]
// Constants and types shared by the general purpose port block.
// Assumes a single system clock and an asynchronous active-high reset.
package gpp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int PORT_BITS      = 12;
    localparam int PORT_COUNT     = 4;
    localparam int PIN_COUNT      = PORT_BITS * PORT_COUNT;
    localparam int WAKE_COUNT     = 13;
    localparam int REGION_BYTES   = 16384;
    localparam int ADDR_BITS      = 14;

    // ------------------------------------------------------------------
    // Reset values (pull field: 0 none, 1 down, 2 up)
    // ------------------------------------------------------------------
    localparam logic [1:0] PULL_NONE  = 2'h0;
    localparam logic [1:0] PULL_DOWN  = 2'h1;
    localparam logic [1:0] PULL_UP    = 2'h2;
    localparam logic [1:0] PULL_RESET = 2'h2;

    // Function select: 0 is the port, others go to peripheral lane
    localparam logic [1:0] FUNC_PORT  = 2'h0;

    // Interrupt sense encoding
    typedef enum logic [1:0] {
        GPP_SENSE_LEVEL,
        GPP_SENSE_RISE,
        GPP_SENSE_FALL,
        GPP_SENSE_BOTH
    } gpp_sense_t;

    // Port write commands
    typedef enum logic [1:0] {
        GPP_CMD_NONE,
        GPP_CMD_WHOLE,
        GPP_CMD_MASKED,
        GPP_CMD_DIR
    } gpp_cmd_t;

endpackage : gpp_pkg

// [gpp_pin_if.sv]
// Interface carrying one pin's sampled level and interrupt settings.
// Assumes sampling and detection run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface gpp_pin_if;
    import gpp_pkg::*;
    logic       level;    // Synchronised pin level
    logic       enable;   // Interrupt enable
    gpp_sense_t sense;    // Level or edge selection
    logic       active_hi;// Level polarity
    logic       hit;      // Interrupt condition

    modport det (input level, enable, sense, active_hi, output hit);
    modport ctl (output level, enable, sense, active_hi, input hit);
endinterface : gpp_pin_if
`default_nettype wire

// [gpp_sync.sv]
// Two flop synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module gpp_sync #(
    parameter int WIDTH = 12
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    import gpp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } gpp_sync_st_t;

    gpp_sync_st_t st_q;
    gpp_sync_st_t st_d;

    // ------------------------------------------------------------------
    // Two stages; only the second stage is read outside
    // ------------------------------------------------------------------
    always_comb begin
        st_d.meta   = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Idle pins sit high on their pull-ups; starting high avoids a false rise
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule : gpp_sync
`default_nettype wire

// [gpp_edge.sv]
// Interrupt detector for one pin: level or edge sensing.
// Assumes the level input is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module gpp_edge (
    input  wire logic   clock,
    input  wire logic   rst,
    gpp_pin_if.det      pin
);
    import gpp_pkg::*;

    typedef struct packed {
        logic prev;
    } gpp_edge_st_t;

    gpp_edge_st_t st_q;
    gpp_edge_st_t st_d;
    logic         rise;
    logic         fall;

    // ------------------------------------------------------------------
    // Detection of the chosen sense
    // ------------------------------------------------------------------
    always_comb begin
        st_d.prev = pin.level;
        rise      = pin.level & ~st_q.prev;
        fall      = ~pin.level & st_q.prev;
        case (pin.sense)
            GPP_SENSE_LEVEL: pin.hit = pin.enable & (pin.level == pin.active_hi);
            GPP_SENSE_RISE:  pin.hit = pin.enable & rise;
            GPP_SENSE_FALL:  pin.hit = pin.enable & fall;
            GPP_SENSE_BOTH:  pin.hit = pin.enable & (rise | fall);
            default:         pin.hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Matches the pulled-up idle level so release gives no edge
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : gpp_edge
`default_nettype wire

// [gpp_port.sv]
// Top of the general purpose port block: pin muxing, output and
// direction control, pull and open-drain settings, pin interrupts.
// Assumes control ports are driven by the fast bus slave logic on the
// same clock, and pin inputs arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module gpp_port #(
    parameter int                          NPINS   = gpp_pkg::PIN_COUNT,
    parameter int                          NWAKE   = gpp_pkg::WAKE_COUNT,
    parameter logic [gpp_pkg::PIN_COUNT-1:0] BONDED = {gpp_pkg::PIN_COUNT{1'b1}},
    parameter logic [gpp_pkg::PIN_COUNT-1:0] TWOWIRE = 48'h0000_0000_0030
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    // Port write command
    input  wire gpp_pkg::gpp_cmd_t           cmd,
    input  wire logic [1:0]                  cmd_port,
    input  wire logic [gpp_pkg::PORT_BITS-1:0] cmd_mask,
    input  wire logic [gpp_pkg::PORT_BITS-1:0] cmd_data,
    // Per-pin configuration
    input  wire logic [2*gpp_pkg::PIN_COUNT-1:0] cfg_func,
    input  wire logic [2*gpp_pkg::PIN_COUNT-1:0] cfg_pull,
    input  wire logic                        cfg_pull_we,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] cfg_open_drain,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] irq_enable,
    input  wire logic [2*gpp_pkg::PIN_COUNT-1:0] irq_sense,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] irq_active_hi,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] irq_clear,
    // Peripheral side
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] periph_out,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] periph_oe,
    output logic      [gpp_pkg::PIN_COUNT-1:0] periph_in,
    output logic      [gpp_pkg::PIN_COUNT-1:0] periph_routed,
    // Pins
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] pin_in,
    output logic      [gpp_pkg::PIN_COUNT-1:0] pin_out,
    output logic      [gpp_pkg::PIN_COUNT-1:0] pin_oe,
    output logic      [2*gpp_pkg::PIN_COUNT-1:0] pin_pull,
    // Readback and interrupts
    output logic      [gpp_pkg::PIN_COUNT-1:0] port_level,
    output logic      [gpp_pkg::PIN_COUNT-1:0] port_dir,
    output logic      [gpp_pkg::PIN_COUNT-1:0] port_data_out,
    output logic      [gpp_pkg::PIN_COUNT-1:0] irq_status,
    output logic      [gpp_pkg::PORT_COUNT-1:0] port_irq,
    output logic      [gpp_pkg::WAKE_COUNT-1:0] wake_irq
);
    import gpp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PIN_COUNT-1:0]   data;
        logic [PIN_COUNT-1:0]   dir;
        logic [2*PIN_COUNT-1:0] pull;
        logic [PIN_COUNT-1:0]   status;
        logic [PIN_COUNT-1:0]   pout;
        logic [PIN_COUNT-1:0]   poe;
        logic [PIN_COUNT-1:0]   pin_s;
        logic [PIN_COUNT-1:0]   pin_r;
        logic [PORT_COUNT-1:0]  pirq;
        logic [WAKE_COUNT-1:0]  wirq;
    } gpp_st_t;

    gpp_st_t              st_q;
    gpp_st_t              st_d;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] hit;
    logic [PIN_COUNT-1:0] routed;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    gpp_sync #(
        .WIDTH    (PIN_COUNT)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (pin_in),
        .sync_out (level)
    );

    // ------------------------------------------------------------------
    // One detector per pin, active whatever function the pin serves
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_det
            gpp_pin_if pif ();
            assign pif.level     = level[g];
            assign pif.enable    = irq_enable[g] & BONDED[g];
            assign pif.sense     = gpp_sense_t'(irq_sense[2*g +: 2]);
            assign pif.active_hi = irq_active_hi[g];
            assign hit[g]        = pif.hit;
            gpp_edge u_edge (
                .clock (clock),
                .rst   (rst),
                .pin   (pif.det)
            );
            // Any nonzero function code hands the pin to a peripheral
            assign routed[g]   = cfg_func[2*g +: 2] != FUNC_PORT;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        int base;
        base = 0;
        st_d = st_q;
        base = int'(cmd_port) * PORT_BITS; // Port select inside the block's own region
        case (cmd) // Taken on every edge, no bridge wait states
            GPP_CMD_WHOLE: begin
                st_d.data[base +: PORT_BITS] = cmd_data;
            end
            GPP_CMD_MASKED: begin
                st_d.data[base +: PORT_BITS] = (st_q.data[base +: PORT_BITS] & ~cmd_mask)
                                             | (cmd_data & cmd_mask);
            end
            GPP_CMD_DIR: begin
                st_d.dir[base +: PORT_BITS] = cmd_data;
            end
            default: begin
            end
        endcase
        // Unbonded bits never hold state
        st_d.data = st_d.data & BONDED;
        st_d.dir  = st_d.dir & BONDED;
        // Pull setting; two-wire pins ignore it
        if (cfg_pull_we) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                st_d.pull[2*i +: 2] = TWOWIRE[i] ? PULL_NONE : cfg_pull[2*i +: 2];
            end
        end
        // Sticky flags: a new hit wins over a clear in the same cycle
        st_d.status = ((st_q.status & ~irq_clear) | hit) & BONDED;
        // Per-pin mux between port logic and peripheral
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (routed[i]) begin
                st_d.pout[i] = periph_out[i];
                st_d.poe[i]  = periph_oe[i];
            end else if (cfg_open_drain[i]) begin
                // Open drain: drive only a low, release a high
                st_d.pout[i] = 1'b0;
                st_d.poe[i]  = st_q.dir[i] & ~st_q.data[i];
            end else begin
                st_d.pout[i] = st_q.data[i];
                st_d.poe[i]  = st_q.dir[i];
            end
        end
        st_d.poe   = st_d.poe & BONDED;
        st_d.pin_s = level;
        st_d.pin_r = routed;
        for (int p = 0; p < PORT_COUNT; p++) begin
            st_d.pirq[p] = |st_d.status[p*PORT_BITS +: PORT_BITS];
        end
        // Lowest pins each give a wake-up line of their own
        st_d.wirq = st_d.status[WAKE_COUNT-1:0];
    end

    // ------------------------------------------------------------------
    // Register; pins come up as inputs with pull-up, two-wire pins with no pull
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q        <= '0;
            for (int i = 0; i < PIN_COUNT; i++) begin
                st_q.pull[2*i +: 2] <= TWOWIRE[i] ? PULL_NONE : PULL_RESET;
            end
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------
    assign pin_out       = st_q.pout;
    assign pin_oe        = st_q.poe;
    assign pin_pull      = st_q.pull;
    assign port_level    = st_q.pin_s;
    assign periph_in     = st_q.pin_s;
    assign periph_routed = st_q.pin_r;
    assign port_dir      = st_q.dir;
    assign port_data_out = st_q.data;
    assign irq_status    = st_q.status;
    assign port_irq      = st_q.pirq;
    assign wake_irq      = st_q.wirq;
endmodule : gpp_port
`default_nettype wire

// [gpp_board.sv]
// Board model for the port block: resolves every pin from device drive,
// board drive and pull setting. Assumes the same system clock.
`timescale 1ns/1ps
`default_nettype none
module gpp_board (
    input  wire logic        clock,
    input  wire logic [47:0] pin_out,
    input  wire logic [47:0] pin_oe,
    input  wire logic [95:0] pin_pull,
    input  wire logic [47:0] ext_en,
    input  wire logic [47:0] ext_val,
    output var  logic [47:0] pin_in
);
    logic flip_q = 1'b0;

    // A bare pin wanders so a stale value never passes for a real one
    always @(posedge clock) flip_q <= ~flip_q;

    // Device drive wins, then the board, then the pull resistor
    always_comb begin
        for (int i = 0; i < 48; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pull[2*i+:2] == 2'h2) pin_in[i] = 1'b1;
            else if (pin_pull[2*i+:2] == 2'h1) pin_in[i] = 1'b0;
            else pin_in[i] = flip_q;
        end
    end
endmodule : gpp_board
`default_nettype wire

// [gpp_port_chk.sv]
// Checker for the port block: write timing, readback and pin flags.
// Assumes one clock and the default of every pin bonded.
`timescale 1ns/1ps
`default_nettype none
module gpp_port_chk
    import gpp_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire gpp_pkg::gpp_cmd_t cmd,
    input wire logic [1:0]        cmd_port,
    input wire logic [11:0]       cmd_mask,
    input wire logic [11:0]       cmd_data,
    input wire logic [95:0]       cfg_func,
    input wire logic [47:0]       cfg_open_drain,
    input wire logic [47:0]       irq_enable,
    input wire logic [95:0]       irq_sense,
    input wire logic [47:0]       pin_in,
    input wire logic [47:0]       pin_out,
    input wire logic [47:0]       pin_oe,
    input wire logic [95:0]       pin_pull,
    input wire logic [47:0]       port_level,
    input wire logic [47:0]       port_data_out,
    input wire logic [47:0]       port_dir,
    input wire logic [47:0]       irq_status,
    input wire logic [3:0]        port_irq,
    input wire logic [12:0]       wake_irq
);
    logic [1:0] up_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Cycles since reset, so pipeline checks skip the refill
    always_ff @(posedge clock or posedge rst) begin
        if (rst) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end

    // --------------------------------------------------------------
    // Port behaviour
    // --------------------------------------------------------------
    property p_mask; cmd == GPP_CMD_MASKED && cmd_port == 2'h0 |=> port_data_out[11:0] ==
        (($past(port_data_out[11:0]) & ~$past(cmd_mask)) | ($past(cmd_data) & $past(cmd_mask))); endproperty
    a_mask: assert property (p_mask) else $error("masked write wrong");
    property p_whole; cmd == GPP_CMD_WHOLE && cmd_port == 2'h0 |=> port_data_out[11:0] == $past(cmd_data); endproperty
    a_whole: assert property (p_whole) else $error("whole write wrong");
    property p_dir; cmd == GPP_CMD_DIR && cmd_port == 2'h0 |=> port_dir[11:0] == $past(cmd_data); endproperty
    a_dir: assert property (p_dir) else $error("direction write wrong");
    property p_out; cmd == GPP_CMD_WHOLE && cmd_port == 2'h0 && cfg_func[15:14] == 2'h0 && !cfg_open_drain[7]
        ##1 cfg_func[15:14] == 2'h0 |=> pin_out[7] == $past(cmd_data[7], 2); endproperty
    a_out: assert property (p_out) else $error("pin not driven by port");
    property p_level; up_q == 2'h3 |-> port_level == $past(pin_in, 3); endproperty
    a_level: assert property (p_level) else $error("readback latency wrong");
    property p_rise; $rose(port_level[6]) && irq_enable[6] && irq_sense[13:12] == 2'h1 |-> irq_status[6]; endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed");
    property p_wake; wake_irq == irq_status[12:0] && port_irq[0] == |irq_status[11:0]; endproperty
    a_wake: assert property (p_wake) else $error("wake or port flag wrong");
    property p_pull_rst; up_q == 2'h1 |-> pin_pull == 96'hAAAA_AAAA_AAAA_AAAA_AAAA_A0AA && pin_oe == 48'h0; endproperty
    a_pull_rst: assert property (p_pull_rst) else $error("reset pin state wrong");
    property p_od; (cfg_open_drain[2] && cfg_func[5:4] == 2'h0) [*3] |-> !pin_out[2]; endproperty
    a_od: assert property (p_od) else $error("open drain drove high");

    c_both: cover property (irq_sense[13:12] == 2'h3 && $rose(irq_status[6]));
    c_mask: cover property (cmd == GPP_CMD_MASKED);
    c_od: cover property ($rose(pin_oe[2]) && cfg_open_drain[2]);
endmodule : gpp_port_chk
bind gpp_port gpp_port_chk u_gpp_port_chk (.*);
`default_nettype wire

// [gpp_port_tb.sv]
// Self-checking bench for the port block with a board model on the pins.
// Assumes default parameters: 48 pins, two-wire pins 4 and 5.
`timescale 1ns/1ps
`default_nettype none
module gpp_port_tb;
    import gpp_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    gpp_cmd_t    cmd = GPP_CMD_NONE;
    logic [1:0]  cmd_port = 2'h0;
    logic [11:0] cmd_mask = 12'h000;
    logic [11:0] cmd_data = 12'h000;
    logic        cfg_pull_we = 1'b0;
    logic [95:0] cfg_func = '0, cfg_pull = '0, irq_sense = '0, pin_pull;
    logic [47:0] cfg_open_drain = '0, irq_enable = '0, irq_active_hi = '1, irq_clear = '0;
    logic [47:0] periph_out = '0, periph_oe = '0, ext_en = '0, ext_val = '0;
    logic [47:0] pin_in, pin_out, pin_oe, periph_in, periph_routed;
    logic [47:0] port_level, port_dir, port_data_out, irq_status;
    logic [3:0]  port_irq;
    logic [12:0] wake_irq;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;

    gpp_port u_gpp_port (.*);
    gpp_board u_gpp_board (.*);

    // 40 MHz clock; a hang is cut after far more cycles than the tests need
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [95:0] seen, input logic [95:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // Held one cycle; back to back calls keep a command every cycle
    task automatic wr(input gpp_cmd_t c, input logic [1:0] p, input logic [11:0] m, input logic [11:0] d);
        cmd = c;
        cmd_port = p;
        cmd_mask = m;
        cmd_data = d;
        cyc(1);
    endtask : wr
    task automatic clr();
        irq_clear[6] = 1'b1;
        cyc(1);
        irq_clear[6] = 1'b0;
    endtask : clr
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        chk(pin_pull, 96'hAAAA_AAAA_AAAA_AAAA_AAAA_A0AA);
        chk(pin_oe, 48'h0);
        cyc(4);
        chk(port_level[3:0], 4'hF);
        $display("done reset");
    endtask : t_reset
    // Back to back writes on two ports; outputs read back as pin levels
    task automatic t_write();
        wr(GPP_CMD_DIR, 2'h0, 12'h000, 12'hF80);
        wr(GPP_CMD_WHOLE, 2'h0, 12'h000, 12'hA5C);
        wr(GPP_CMD_MASKED, 2'h0, 12'h0F0, 12'h030);
        wr(GPP_CMD_WHOLE, 2'h1, 12'h000, 12'h123);
        wr(GPP_CMD_MASKED, 2'h1, 12'h00F, 12'h0F0);
        cmd = GPP_CMD_NONE;
        cyc(4);
        chk(port_data_out[23:0], 24'h120A3C);
        chk(port_dir[11:0], 12'hF80);
        chk({pin_oe[11:7], pin_out[11:7]}, 10'h3F4);
        chk(port_level[11:7], 5'h14);
        $display("done write");
    endtask : t_write
    // Every sense mode on pin 6, which also feeds the wake logic
    task automatic t_irq();
        irq_enable[6] = 1'b1;
        ext_en[6] = 1'b1;
        for (int s = 0; s < 4; s++) begin
            irq_sense[13:12] = s[1:0];
            ext_val[6] = 1'b0;
            cyc(5);
            clr();
            cyc(1);
            chk(irq_status[6], 1'b0);
            ext_val[6] = 1'b1;
            cyc(5);
            chk(irq_status[6], s != 2);
            chk({wake_irq[6], port_irq[0]}, {2{s != 2}});
            clr();
            ext_val[6] = 1'b0;
            cyc(5);
            chk(irq_status[6], s != 1);
        end
        // Active-low level sense: a low pin holds the flag up
        irq_sense[13:12] = 2'h0;
        irq_active_hi[6] = 1'b0;
        ext_val[6] = 1'b1;
        cyc(5);
        clr();
        cyc(1);
        chk(irq_status[6], 1'b0);
        ext_val[6] = 1'b0;
        cyc(5);
        chk(irq_status[6], 1'b1);
        irq_active_hi[6] = 1'b1;
        irq_enable[6] = 1'b0;
        ext_en[6] = 1'b0;
        $display("done irq");
    endtask : t_irq
    task automatic t_route();
        cfg_func[3:2] = 2'h1;
        cyc(1);
        periph_oe[1] = 1'b1;
        periph_out[1] = 1'b1;
        cyc(5);
        chk({periph_routed[1], pin_oe[1], pin_out[1], periph_in[1]}, 4'hF);
        periph_out[1] = 1'b0;
        cyc(5);
        chk({pin_out[1], periph_in[1]}, 2'h0);
        cfg_func[3:2] = 2'h0;
        periph_oe[1] = 1'b0;
        cyc(5);
        chk({periph_routed[1], pin_oe[1]}, 2'h0);
        $display("done route");
    endtask : t_route
    task automatic t_od();
        cfg_open_drain[2] = 1'b1;
        wr(GPP_CMD_DIR, 2'h0, 12'h000, 12'hF84);
        wr(GPP_CMD_MASKED, 2'h0, 12'h004, 12'h004);
        cmd = GPP_CMD_NONE;
        cyc(5);
        chk({pin_oe[2], port_level[2]}, 2'h1);
        wr(GPP_CMD_MASKED, 2'h0, 12'h004, 12'h000);
        cmd = GPP_CMD_NONE;
        cyc(5);
        chk({pin_oe[2], pin_out[2], port_level[2]}, 3'h4);
        $display("done open drain");
    endtask : t_od
    task automatic t_pull();
        cfg_pull = {48{2'h1}};
        cfg_pull_we = 1'b1;
        cyc(1);
        cfg_pull_we = 1'b0;
        cyc(5);
        chk(pin_pull, 96'h5555_5555_5555_5555_5555_5055);
        chk(port_level[3], 1'b0);
        $display("done pull");
    endtask : t_pull

    // Reset for 8 cycles, then the scenarios in turn
    initial begin
        cyc(8);
        rst = 1'b0;
        t_reset();
        t_write();
        t_irq();
        t_route();
        t_od();
        t_pull();
        finish_test();
    end
endmodule : gpp_port_tb
`default_nettype wire
